// file: pkg/vgaftd_pkg.sv
package vgaftd_pkg;
	localparam logic [31:0] WB_CTRL = 32'h0000_0000;
	localparam logic [31:0] WB_STAT = 32'h0000_0004;
	localparam logic [31:0] WB_TADDR = 32'h0000_0008;
	localparam logic [31:0] WB_TDATA = 32'h0000_000C;
	localparam logic [31:0] WB_TINFO = 32'h0000_0010;
	localparam logic [31:0] WB_REFR = 32'h0000_0014;
	localparam logic [31:0] MEM_LO = 32'h000A_0000;
	localparam logic [31:0] MEM_HI = 32'h000B_FFFF;
	localparam logic [31:0] EGA_LO = 32'h000A_0000;
	localparam logic [31:0] EGA_HI = 32'h000B_0000;
	localparam logic [31:0] MONO_LO = 32'h000B_0000;
	localparam logic [31:0] MONO_HI = 32'h000B_7FFF;
	localparam logic [31:0] COL_LO = 32'h000B_8000;
	localparam logic [31:0] COL_HI = 32'h000B_FFFF;
	localparam logic [15:0] IO_LO = 16'h03B0;
	localparam logic [15:0] IO_HI = 16'h03DF;
	localparam int CTRL_MAP_POS = 0;
	localparam int CTRL_CHAIN_POS = 2;
	localparam int CTRL_MASK_POS = 4;
	localparam int CTRL_PAGE_POS = 8;
	localparam int CTRL_MTRAP_POS = 9;
	localparam int CTRL_RTRAP_POS = 10;
	localparam logic [31:0] CTRL_RESET = 32'h0000_02F0;
	localparam int STAT_PEND_POS = 0;
	localparam int STAT_CNT_POS = 8;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_DWORD = 2'h2;

	typedef enum logic [1:0] {MAP_ALL, MAP_EGA, MAP_MONO, MAP_COL} vgaftd_map_t;
	typedef enum logic [1:0] {CH_NONE, CH_ODDEVEN, CH_FOUR, CH_RSVD} vgaftd_chain_t;

	typedef struct packed {
		logic valid;
		logic is_io;
		logic we;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} vgaftd_host_req_t;

	typedef struct packed {
		logic valid;
		logic we;
		logic [15:0] addr;
		logic [3:0] be;
		logic [7:0] data;
	} vgaftd_fb_req_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} vgaftd_wb_req_t;
endpackage

// file: core/vgaftd_core.sv
// What this block does
// - trap detection drives management interrupt low
// - trap all display I/O; memory optionally
// - memory writes in window raise interrupt
// - display I/O reads and writes raise interrupt
// - display accesses never reach external bus
// - window spans A0000h through BFFFFh
// - window selectable among three sub-ranges
// - I/O space 3B0h to 3DFh decoded
// - frame buffer is 64K words of 32 bits
// - plane n is byte n of word
// - word addressing; byte enables only on writes
// - eight 4-bit pixels decoded per word
// - wide host accesses split into bytes
// - bits 31:15 decode hit; 15:0 word address
// - default enables come from plane write mask
// - odd/even: address bit0 picks byte pairs
// - odd/even: word bit0 is page select
// - four-way: one enable, address low bits zero
// - chained enables ANDed with plane write mask
// - front-end and refresh fields kept separate
// - text modes not refreshed directly
// - display memory kept apart from system memory
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module vgaftd_core #(
	parameter int FB_WORDS = 65536
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire vgaftd_pkg::vgaftd_host_req_t host_req,
	output logic host_ready,
	output logic host_hit,
	output logic ext_bus_req,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	output logic sys_mgmt_interrupt_n,
	input wire logic sys_mgmt_exec_state,
	input wire logic [15:0] refresh_addr,
	output logic [31:0] refresh_pixels,
	input wire vgaftd_pkg::vgaftd_wb_req_t wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o
);
	import vgaftd_pkg::*;

	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] refr;
		logic pend;
		logic [7:0] cnt;
		logic [31:0] taddr;
		logic [31:0] tdata;
		logic [3:0] tinfo;
		logic busy;
		logic [1:0] idx;
		logic [1:0] last;
		logic [31:0] cur_addr;
		logic [31:0] cur_data;
		logic cur_we;
		logic host_ready;
		logic host_hit;
		logic [7:0] host_rdata;
		logic host_rvalid;
		logic smi_n;
		logic [31:0] pix;
		logic wb_ack;
		logic [31:0] wb_dat;
	} vgaftd_state_t;

	vgaftd_state_t st_reg;
	vgaftd_state_t st_next;
	logic [31:0] fb [FB_WORDS];
	vgaftd_fb_req_t fb_req;
	logic [31:0] ref_word;

	// window hit under the selected map
	function automatic logic in_window(input logic [31:0] a, input logic [1:0] map);
		logic r;
		r = 1'b0;
		if (a[31:15] >= MEM_LO[31:15] && a[31:15] <= MEM_HI[31:15]) begin
			case (map)
				MAP_ALL: r = (a >= MEM_LO) && (a <= MEM_HI);
				MAP_EGA: r = (a >= EGA_LO) && (a < EGA_HI);
				MAP_MONO: r = (a >= MONO_LO) && (a <= MONO_HI);
				MAP_COL: r = (a >= COL_LO) && (a <= COL_HI);
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	function automatic logic in_io(input logic [31:0] a);
		return (a[31:16] == 16'h0000) && (a[15:0] >= IO_LO) && (a[15:0] <= IO_HI);
	endfunction

	// byte lane steering for one byte of a wide host access
	function automatic logic [7:0] lane(input logic [31:0] d, input logic [1:0] i);
		return d[8 * i +: 8];
	endfunction

	////////////////////////////////////////////////////////////////
	// frame-buffer address and enable translation
	always_comb begin
		logic [3:0] mask;
		logic [15:0] wa;
		logic [3:0] be;
		mask = st_reg.ctrl[CTRL_MASK_POS +: 4];
		wa = st_reg.cur_addr[15:0];
		be = mask;
		case (st_reg.ctrl[CTRL_CHAIN_POS +: 2])
			CH_ODDEVEN: begin
				be = (st_reg.cur_addr[0] ? 4'hA : 4'h5) & mask;
				wa[0] = st_reg.ctrl[CTRL_PAGE_POS];
			end
			CH_FOUR: begin
				be = (4'h1 << st_reg.cur_addr[1:0]) & mask;
				wa[1:0] = 2'h0;
			end
			default: be = mask;
		endcase
		fb_req.valid = st_reg.busy && st_reg.host_hit;
		fb_req.we = st_reg.cur_we;
		fb_req.addr = wa;
		fb_req.be = be;
		fb_req.data = lane(st_reg.cur_data, st_reg.idx);
	end

	// display memory is its own array, apart from system memory
	always_ff @(posedge clk_sys) begin
		if (fb_req.valid && fb_req.we) begin
			for (int p = 0; p < 4; p++) begin
				if (fb_req.be[p]) begin
					fb[fb_req.addr][8 * p +: 8] <= fb_req.data;
				end
			end
		end
		ref_word <= fb[refresh_addr];
	end

	////////////////////////////////////////////////////////////////
	always_comb begin
		logic hit_mem;
		logic hit_io;
		logic trap;
		logic [31:0] pix;
		st_next = st_reg;
		st_next.host_rvalid = 1'b0;
		st_next.wb_ack = 1'b0;
		hit_mem = in_window(host_req.addr, st_reg.ctrl[CTRL_MAP_POS +: 2]);
		hit_io = in_io(host_req.addr);
		trap = 1'b0;

		// refresh path only looks at refresh fields
		pix = 32'h0000_0000;
		for (int i = 0; i < 8; i++) begin
			for (int j = 0; j < 4; j++) begin
				pix[4 * i + j] = ref_word[j * 8 + (7 - i)];
			end
		end
		// text layouts are left to handler-converted buffers
		st_next.pix = st_reg.refr[0] ? pix : ref_word;

		if (st_reg.busy) begin
			if (!st_reg.cur_we) begin
				// same-cycle array read so each split byte sees its own word
				st_next.host_rdata = lane(fb[fb_req.addr], st_reg.ctrl[CTRL_MASK_POS +: 2]);
			end
			if (st_reg.idx == st_reg.last) begin
				st_next.busy = 1'b0;
				st_next.host_ready = 1'b1;
				st_next.host_rvalid = !st_reg.cur_we;
			end else begin
				st_next.idx = st_reg.idx + 2'h1;
				st_next.cur_addr = st_reg.cur_addr + 32'h0000_0001;
			end
		end else if (host_req.valid && st_reg.host_ready) begin
			st_next.host_hit = (hit_mem && !host_req.is_io) || (hit_io && host_req.is_io);
			if (host_req.is_io && hit_io) begin
				trap = 1'b1;
			end else if (!host_req.is_io && hit_mem) begin
				// memory traps are optional so direct-display modes run at speed
				trap = (host_req.we && st_reg.ctrl[CTRL_MTRAP_POS])
					|| (!host_req.we && st_reg.ctrl[CTRL_RTRAP_POS]);
				st_next.busy = 1'b1;
				st_next.host_ready = 1'b0;
				st_next.idx = 2'h0;
				st_next.last = (host_req.size == SIZE_DWORD) ? 2'h3 :
					(host_req.size == SIZE_WORD) ? 2'h1 : 2'h0;
				st_next.cur_addr = host_req.addr;
				st_next.cur_data = host_req.wdata;
				st_next.cur_we = host_req.we;
			end
		end

		// handler clears pending over the bus; a new trap in that cycle wins
		if (wb_req.cyc && wb_req.stb && !st_reg.wb_ack) begin
			st_next.wb_ack = 1'b1;
			st_next.wb_dat = 32'h0000_0000;
			case (wb_req.adr)
				WB_CTRL: begin
					if (wb_req.we) begin
						for (int b = 0; b < 4; b++) begin
							if (wb_req.sel[b]) begin
								st_next.ctrl[8 * b +: 8] = wb_req.dat[8 * b +: 8];
							end
						end
					end
					st_next.wb_dat = st_reg.ctrl;
				end
				WB_STAT: begin
					if (wb_req.we && wb_req.sel[0] && wb_req.dat[STAT_PEND_POS]) begin
						st_next.pend = 1'b0;
					end
					st_next.wb_dat = {16'h0000, st_reg.cnt, 7'h00, st_reg.pend};
				end
				WB_TADDR: st_next.wb_dat = st_reg.taddr;
				WB_TDATA: st_next.wb_dat = st_reg.tdata;
				WB_TINFO: st_next.wb_dat = {28'h0000000, st_reg.tinfo};
				WB_REFR: begin
					if (wb_req.we && wb_req.sel[0]) begin
						st_next.refr[7:0] = wb_req.dat[7:0];
					end
					st_next.wb_dat = st_reg.refr;
				end
				default: st_next.wb_dat = 32'h0000_0000;
			endcase
		end

		if (trap) begin
			st_next.pend = 1'b1;
			st_next.cnt = st_reg.cnt + 8'h01;
			st_next.taddr = host_req.addr;
			st_next.tdata = host_req.wdata;
			st_next.tinfo = {host_req.is_io, host_req.we, host_req.size};
		end
		// interrupt held low while pending, released in management mode
		st_next.smi_n = !(st_next.pend && !sys_mgmt_exec_state);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.ctrl <= CTRL_RESET;
			st_reg.host_ready <= 1'b1;
			st_reg.smi_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign host_ready = st_reg.host_ready;
	assign host_hit = st_reg.host_hit;
	assign ext_bus_req = 1'b0;
	assign host_rdata = st_reg.host_rdata;
	assign host_rvalid = st_reg.host_rvalid;
	assign sys_mgmt_interrupt_n = st_reg.smi_n;
	assign refresh_pixels = st_reg.pix;
	assign wb_ack = st_reg.wb_ack;
	assign wb_dat_o = st_reg.wb_dat;
endmodule
`default_nettype wire

// file: tb/vgaftd_checker.sv
`timescale 1ns/100ps
`default_nettype none
module vgaftd_checker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire vgaftd_pkg::vgaftd_host_req_t host_req,
	input wire logic host_ready,
	input wire logic host_hit,
	input wire logic ext_bus_req,
	input wire logic host_rvalid,
	input wire logic sys_mgmt_interrupt_n,
	input wire logic sys_mgmt_exec_state,
	input wire vgaftd_pkg::vgaftd_wb_req_t wb_req,
	input wire logic wb_ack
);
	import vgaftd_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic acc, io_in, out_win;
	assign acc = host_req.valid && host_ready;
	assign io_in = host_req.is_io && host_req.addr[15:0] >= IO_LO && host_req.addr[15:0] <= IO_HI;
	assign out_win = !host_req.is_io && (host_req.addr < MEM_LO || host_req.addr > MEM_HI);
	sequence s_dword;
		acc && !host_req.is_io && host_req.size == SIZE_DWORD ##1 host_hit;
	endsequence
	sequence s_byte;
		acc && !host_req.is_io && host_req.size == SIZE_BYTE ##1 host_hit;
	endsequence
	a_no_ext_bus: assert property (!ext_bus_req) else $error("external cycle");
	a_io_trap_smi: assert property (acc && io_in |=> !sys_mgmt_interrupt_n || sys_mgmt_exec_state)
		else $error("io access without interrupt");
	a_io_hit: assert property (acc && io_in |=> host_hit) else $error("io not decoded");
	a_window_miss: assert property (acc && out_win |=> !host_hit) else $error("false hit");
	a_dword_split: assert property (s_dword |-> !host_ready [*4] ##1 host_ready)
		else $error("dword not four bytes");
	a_byte_single: assert property (s_byte |-> !host_ready ##1 host_ready)
		else $error("byte not one step");
	a_exec_quiet: assert property (sys_mgmt_exec_state [*2] |-> sys_mgmt_interrupt_n)
		else $error("interrupt inside handler");
	a_wb_answer: assert property (wb_req.cyc && wb_req.stb && !wb_ack |=> wb_ack)
		else $error("no ack");
	a_wb_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
	a_rvalid_pulse: assert property (host_rvalid |=> !host_rvalid) else $error("rvalid long");
endmodule
bind vgaftd_core vgaftd_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .host_req(host_req),
	.host_ready(host_ready), .host_hit(host_hit), .ext_bus_req(ext_bus_req),
	.host_rvalid(host_rvalid), .sys_mgmt_interrupt_n(sys_mgmt_interrupt_n),
	.sys_mgmt_exec_state(sys_mgmt_exec_state), .wb_req(wb_req), .wb_ack(wb_ack));
`default_nettype wire

// file: tb/vgaftd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module vgaftd_host_model (
	input wire logic clk_sys,
	input wire logic host_ready,
	output var vgaftd_pkg::vgaftd_host_req_t host_req
);
	import vgaftd_pkg::*;
	initial host_req = '0;
	// address kept after accept, though the core walks split bytes from its own copy
	task automatic access(input logic io, we, input logic [1:0] sz, input logic [31:0] a, d);
		@(posedge clk_sys);
		host_req <= '{1'b1, io, we, sz, a, d};
		do @(posedge clk_sys); while (!host_ready);
		host_req.valid <= 1'b0;
		// no local limit: only the bench timeout ends a hung access
		do @(posedge clk_sys); while (!host_ready);
	endtask
endmodule
`default_nettype wire

// file: tb/vga_frontend_trap_decode_tb.sv
`timescale 1ns/100ps
`default_nettype none
module vga_frontend_trap_decode_tb;
	import vgaftd_pkg::*;
	logic clk_sys, resetn, host_ready, host_hit, ext_bus_req, host_rvalid, wb_ack;
	logic sys_mgmt_interrupt_n, sys_mgmt_exec_state;
	logic [7:0] host_rdata;
	logic [15:0] refresh_addr;
	logic [31:0] refresh_pixels, wb_dat_o, rd;
	logic [31:0] probe [4] = '{32'h000A_0000, 32'h000B_4000, 32'h000B_8000, 32'h000C_0000};
	vgaftd_host_req_t host_req;
	vgaftd_wb_req_t wb_req;
	int error_cnt = 0;
	int checked = 0;
	int cyc_cnt = 0;
	vgaftd_core u_dut (.clk_sys(clk_sys), .resetn(resetn), .host_req(host_req),
		.host_ready(host_ready), .host_hit(host_hit), .ext_bus_req(ext_bus_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.sys_mgmt_interrupt_n(sys_mgmt_interrupt_n), .sys_mgmt_exec_state(sys_mgmt_exec_state),
		.refresh_addr(refresh_addr), .refresh_pixels(refresh_pixels), .wb_req(wb_req),
		.wb_ack(wb_ack), .wb_dat_o(wb_dat_o));
	vgaftd_host_model u_host (.clk_sys(clk_sys), .host_ready(host_ready), .host_req(host_req));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [31:0] a, d, output logic [31:0] q);
		@(posedge clk_sys);
		wb_req <= '{1'b1, 1'b1, we, 4'hF, a, d};
		do @(posedge clk_sys); while (!wb_ack);
		q = wb_dat_o;
		wb_req <= '0;
	endtask
	task automatic fb(input logic [15:0] a, input logic [31:0] exp);
		refresh_addr <= a;
		repeat (3) @(posedge clk_sys);
		check(refresh_pixels, exp);
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		resetn = 1'b0;
		sys_mgmt_exec_state = 1'b0;
		refresh_addr = 16'h0;
		wb_req = '0;
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		wb(1'b0, WB_CTRL, 32'h0, rd);
		check(rd, CTRL_RESET);
		wb(1'b0, 32'h0000_0040, 32'h0, rd);
		check(rd, 32'h0);
		u_host.access(1'b1, 1'b1, SIZE_BYTE, 32'h0000_03D4, 32'h11);
		wb(1'b0, WB_TINFO, 32'h0, rd);
		check(rd, 32'hC);
		wb(1'b0, WB_TADDR, 32'h0, rd);
		check(rd, 32'h0000_03D4);
		check(sys_mgmt_interrupt_n, 32'h0);
		sys_mgmt_exec_state <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(sys_mgmt_interrupt_n, 32'h1);
		sys_mgmt_exec_state <= 1'b0;
		wb(1'b1, WB_STAT, 32'h1, rd);
		u_host.access(1'b1, 1'b0, SIZE_BYTE, 32'(IO_LO), 32'h0);
		u_host.access(1'b1, 1'b0, SIZE_BYTE, 32'h0000_03E0, 32'h0);
		wb(1'b0, WB_TINFO, 32'h0, rd);
		check(rd, 32'h8);
		wb(1'b0, WB_STAT, 32'h0, rd);
		check(rd & 32'hFF01, 32'h0201);
		u_host.access(1'b0, 1'b1, SIZE_DWORD, MEM_LO, 32'h4433_2211);
		wb(1'b0, WB_TDATA, 32'h0, rd);
		check(rd, 32'h4433_2211);
		wb(1'b0, WB_TINFO, 32'h0, rd);
		check(rd, 32'h6);
		for (int k = 0; k < 4; k++) fb(16'(k), {4{8'(8'h11 * (k + 1))}});
		wb(1'b1, WB_CTRL, 32'h0000_02F8, rd);
		for (int k = 0; k < 4; k++) u_host.access(1'b0, 1'b1, SIZE_BYTE, MEM_LO + 4 + k, 32'h11 << k);
		wb(1'b1, WB_CTRL, 32'h0000_0218, rd);
		u_host.access(1'b0, 1'b1, SIZE_BYTE, MEM_LO + 5, 32'hFF);
		fb(16'h4, 32'h8844_2211);
		wb(1'b1, WB_REFR, 32'h1, rd);
		fb(16'h4, 32'h1248_1248);
		wb(1'b1, WB_REFR, 32'h0, rd);
		wb(1'b1, WB_CTRL, 32'h0000_03F4, rd);
		u_host.access(1'b0, 1'b1, SIZE_BYTE, MEM_LO + 8, 32'h5A);
		u_host.access(1'b0, 1'b1, SIZE_BYTE, MEM_LO + 9, 32'hC3);
		fb(16'h9, 32'hC35A_C35A);
		wb(1'b1, WB_STAT, 32'h1, rd);
		for (int m = 0; m < 4; m++) begin
			wb(1'b1, WB_CTRL, 32'h0000_02F0 | m, rd);
			for (int k = 0; k < 4; k++) begin
				u_host.access(1'b0, 1'b0, SIZE_BYTE, probe[k], 32'h0);
				check(host_hit, 16'hE842 >> (15 - 4 * m - k) & 1);
			end
		end
		wb(1'b0, WB_STAT, 32'h0, rd);
		check(rd[0], 32'h0);
		// read trap on, write trap off
		wb(1'b1, WB_CTRL, 32'h0000_04F0, rd);
		u_host.access(1'b0, 1'b1, SIZE_BYTE, MEM_LO + 16, 32'h77);
		wb(1'b0, WB_STAT, 32'h0, rd);
		check(rd[0], 32'h0);
		u_host.access(1'b0, 1'b0, SIZE_BYTE, MEM_LO + 4, 32'h0);
		check(host_rdata, 32'h88);
		wb(1'b0, WB_TINFO, 32'h0, rd);
		check(rd, 32'h0);
		wb(1'b0, WB_TADDR, 32'h0, rd);
		check(rd, MEM_LO + 4);
		wb(1'b0, WB_STAT, 32'h0, rd);
		check(rd[0], 32'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
